// ### rtl/radio_spi_pkg.sv
// shared constants, types and decoders for the radio serial port and modes
package radio_spi_pkg;

  // ==========================================================================
  // clock and timing
  localparam int unsigned CORE_CLK_HZ        = 10_000_000;
  localparam int unsigned CORE_PERIOD_NS     = 100;
  localparam int unsigned OFF_TO_IDLE_MIN_MS = 10;
  localparam int unsigned HIB_TO_IDLE_MIN_MS = 7;
  localparam int unsigned DOZE_WAKE_US       = 300;
  localparam int unsigned RADIO_WARM_US      = 144;
  localparam int unsigned SCLK_MIN_PERIOD_NS = 125;
  localparam int unsigned OFF_TO_IDLE_CYCLES =
    OFF_TO_IDLE_MIN_MS * (CORE_CLK_HZ / 1000);
  localparam int unsigned HIB_TO_IDLE_CYCLES =
    HIB_TO_IDLE_MIN_MS * (CORE_CLK_HZ / 1000);
  localparam int unsigned DOZE_WAKE_CYCLES   =
    DOZE_WAKE_US * (CORE_CLK_HZ / 1_000_000);
  localparam int unsigned RADIO_WARM_CYCLES  =
    RADIO_WARM_US * (CORE_CLK_HZ / 1_000_000);
  // half period of the serial clock; far above the minimum period because
  // the far end sees every pin through a two-stage synchroniser
  localparam int unsigned SCLK_MIN_HALF =
    (SCLK_MIN_PERIOD_NS + 2 * CORE_PERIOD_NS - 1) / (2 * CORE_PERIOD_NS);
  localparam int unsigned SCLK_HALF_CYCLES = 8;
  localparam int unsigned WAIT_W           = 20;
  localparam logic [3:0]  HALF_LAST        = 4'(SCLK_HALF_CYCLES - 1);

  // ==========================================================================
  // header and register layout
  localparam int unsigned HDR_RW_BIT      = 7;
  localparam int unsigned HDR_ADDR_W      = 6;
  localparam int unsigned REG_COUNT       = 8;
  localparam logic [2:0]  MODE_REG_IDX    = 3'h1;
  localparam logic [2:0]  DOZE_TIMER_IDX  = 3'h2;
  localparam logic [2:0]  CLOCK_OUTPUT_CTRL_IDX   = 3'h7;
  localparam int unsigned CLOCK_OUTPUT_EN_BIT     = 9;
  localparam int unsigned CLOCK_OUTPUT_DIV_W      = 4;
  localparam int unsigned MODE_TX_BIT     = 2;
  localparam logic [1:0]  CMD_HIBERNATE   = 2'h1;
  localparam logic [1:0]  CMD_DOZE        = 2'h2;
  localparam logic [15:0] REG_RESET       = 16'h0000;
  localparam logic [15:0] CLOCK_OUTPUT_CTRL_RESET = 16'h000F;
  localparam int unsigned CLOCK_OUTPUT_MAX_HZ     = 1_000_000;
  localparam logic [3:0]  CLOCK_OUTPUT_MIN_DIV    =
    4'(CORE_CLK_HZ / (2 * CLOCK_OUTPUT_MAX_HZ) - 1);

  // ==========================================================================
  // host command buffer
  localparam int unsigned CMD_W      = 9;
  localparam int unsigned FIFO_DEPTH = 4;

  // ==========================================================================
  // state types
  typedef enum logic [3:0] {
    M_OFF       = 4'h0,
    M_POWER_UP  = 4'h1,
    M_IDLE      = 4'h2,
    M_HIBERNATE = 4'h3,
    M_HIB_WAKE  = 4'h4,
    M_DOZE      = 4'h5,
    M_DOZE_WAKE = 4'h6,
    M_RX_WARM   = 4'h7,
    M_RX        = 4'h8,
    M_TX_WARM   = 4'h9,
    M_TX        = 4'hA
  } mode_t;

  typedef enum logic [2:0] {
    H_IDLE  = 3'h0,
    H_LOW   = 3'h1,
    H_HIGH  = 3'h2,
    H_FETCH = 3'h3,
    H_END   = 3'h4,
    H_GAP   = 3'h5
  } host_state_t;

  // upper address bits alias onto the small register store
  function automatic logic [2:0] reg_index(input logic [5:0] addr,
                                           input logic [5:0] word);
    logic [5:0] sum;
    sum = addr + word;
    return sum[2:0];
  endfunction : reg_index

endpackage : radio_spi_pkg

// ### rtl/spi_link_if.sv
// pin bundle between the host controller and the radio device
`timescale 1ns/100ps
`default_nettype none
interface spi_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  logic miso_oe_n;
  logic miso_line;
  logic attention_n;
  logic seq_enable;
  logic clock_output;
  logic clock_output_oe_n;
  logic irq_n;
  logic irq_oe_n;

  // a released line is modelled as pulled low
  assign miso_line = miso_oe_n ? 1'b0 : miso;

  modport device (input sclk, cs_n, mosi, attention_n, seq_enable,
                  output miso, miso_oe_n, clock_output, clock_output_oe_n,
                  irq_n, irq_oe_n);
  modport host (output sclk, cs_n, mosi, attention_n, seq_enable,
                input miso_line, clock_output, irq_n);
endinterface : spi_link_if
`default_nettype wire

// ### rtl/byte_fifo.sv
// flop-based fifo with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module byte_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             core_clk_in,
  input  wire logic             resetn_in,
  input  wire logic             clk_en_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  output logic [WIDTH-1:0]      out_data_out,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in
);
  localparam int unsigned PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0]    wr_ptr_reg;
  logic [PW-1:0]    rd_ptr_reg;
  logic [PW:0]      count_reg;
  logic [PW:0]      count_next;

  wire push = in_valid_in && in_ready_out;
  wire pop  = out_valid_out && out_ready_in;

  assign count_next   = count_reg + (PW+1)'(push) - (PW+1)'(pop);
  assign out_data_out = mem_reg[rd_ptr_reg];

  always_ff @(posedge core_clk_in)
    if (!resetn_in)
    begin
      wr_ptr_reg    <= '0;
      rd_ptr_reg    <= '0;
      count_reg     <= '0;
      in_ready_out  <= 1'b1;
      out_valid_out <= 1'b0;
    end
    else if (clk_en_in)
    begin
      if (push)
      begin
        mem_reg[wr_ptr_reg] <= in_data_in;
        wr_ptr_reg          <= PW'((wr_ptr_reg + 1'b1) % DEPTH);
      end
      if (pop)
        rd_ptr_reg <= PW'((rd_ptr_reg + 1'b1) % DEPTH);
      count_reg     <= count_next;
      in_ready_out  <= count_next != (PW+1)'(DEPTH);
      out_valid_out <= count_next != '0;
    end
endmodule : byte_fifo
`default_nettype wire

// ### rtl/radio_spi_host.sv
// host end: serial master that frames transactions from a command fifo
`timescale 1ns/100ps
`default_nettype none
module radio_spi_host (
  input  wire logic           core_clk_in,
  input  wire logic           resetn_in,
  input  wire logic           clk_en_in,
  spi_link_if.host            link,
  input  wire logic [7:0]     cmd_data_in,
  input  wire logic           cmd_last_in,
  input  wire logic           cmd_valid_in,
  output logic                cmd_ready_out,
  output logic [7:0]          rsp_data_out,
  output logic                rsp_valid_out,
  output logic                busy_out,
  input  wire logic           wake_req_in,
  input  wire logic           seq_enable_in
);
  import radio_spi_pkg::*;

  // ==========================================================================
  // command buffer
  logic [CMD_W-1:0] f_data;
  logic             f_valid;
  logic             f_pop;

  byte_fifo #(.WIDTH(CMD_W), .DEPTH(FIFO_DEPTH)) cmd_fifo (
    .core_clk_in   (core_clk_in),
    .resetn_in     (resetn_in),
    .clk_en_in     (clk_en_in),
    .in_data_in    ({cmd_last_in, cmd_data_in}),
    .in_valid_in   (cmd_valid_in),
    .in_ready_out  (cmd_ready_out),
    .out_data_out  (f_data),
    .out_valid_out (f_valid),
    .out_ready_in  (f_pop)
  );

  // ==========================================================================
  // serial engine
  host_state_t state_reg;
  logic [3:0]  half_reg;
  logic [2:0]  bit_reg;
  logic [7:0]  tx_reg;
  logic [7:0]  rx_reg;
  logic [1:0]  n_reg;
  logic        odd_reg;
  logic        last_reg;
  logic        read_reg;
  logic        miso_s1_reg;
  logic        miso_s2_reg;
  logic        sclk_reg;
  logic        cs_n_reg;
  logic        mosi_reg;
  logic        att_n_reg;
  logic        seq_reg;

  wire half_done = half_reg == HALF_LAST;
  wire [1:0] n_inc = (n_reg == 2'h3) ? 2'h3 : n_reg + 2'h1;
  // total bytes odd means even payload behind the header
  wire tx_end = last_reg && n_inc == 2'h3 && !odd_reg;
  wire [7:0] rx_byte = {rx_reg[6:0], miso_s2_reg};

  assign f_pop = f_valid && ((state_reg == H_IDLE) ||
                 (state_reg == H_FETCH && !last_reg));

  assign link.sclk        = sclk_reg;
  assign link.cs_n        = cs_n_reg;
  assign link.mosi        = mosi_reg;
  assign link.attention_n = att_n_reg;
  assign link.seq_enable  = seq_reg;

  always_ff @(posedge core_clk_in)
    if (!resetn_in)
    begin
      state_reg     <= H_IDLE;
      half_reg      <= 4'h0;
      bit_reg       <= 3'h0;
      tx_reg        <= 8'h00;
      rx_reg        <= 8'h00;
      n_reg         <= 2'h0;
      odd_reg       <= 1'b0;
      last_reg      <= 1'b0;
      read_reg      <= 1'b0;
      miso_s1_reg   <= 1'b0;
      miso_s2_reg   <= 1'b0;
      sclk_reg      <= 1'b0;
      cs_n_reg      <= 1'b1;
      mosi_reg      <= 1'b0;
      att_n_reg     <= 1'b1;
      seq_reg       <= 1'b0;
      rsp_data_out  <= 8'h00;
      rsp_valid_out <= 1'b0;
      busy_out      <= 1'b0;
    end
    else if (clk_en_in)
    begin
      miso_s1_reg   <= link.miso_line;
      miso_s2_reg   <= miso_s1_reg;
      att_n_reg     <= !wake_req_in;
      seq_reg       <= seq_enable_in;
      rsp_valid_out <= 1'b0;
      half_reg      <= half_done ? 4'h0 : half_reg + 4'h1;
      busy_out      <= state_reg != H_IDLE || f_valid;
      unique case (state_reg)
        H_IDLE:
        begin
          half_reg <= 4'h0;
          if (f_valid)
          begin
            // select falls with the header msb already on the line
            cs_n_reg  <= 1'b0;
            tx_reg    <= f_data[7:0];
            mosi_reg  <= f_data[7];
            read_reg  <= f_data[HDR_RW_BIT];
            last_reg  <= f_data[8];
            bit_reg   <= 3'h0;
            n_reg     <= 2'h0;
            odd_reg   <= 1'b0;
            state_reg <= H_LOW;
          end
        end
        H_LOW:
          if (half_done)
          begin
            sclk_reg  <= 1'b1;
            rx_reg    <= rx_byte;
            state_reg <= H_HIGH;
          end
        H_HIGH:
          if (half_done)
          begin
            sclk_reg <= 1'b0;
            bit_reg  <= bit_reg + 3'h1;
            if (bit_reg == 3'h7)
            begin
              n_reg   <= n_inc;
              odd_reg <= !odd_reg;
              if (read_reg && n_reg != 2'h0)
              begin
                rsp_data_out  <= rx_reg;
                rsp_valid_out <= 1'b1;
              end
              state_reg <= tx_end ? H_END : H_FETCH;
            end
            else
            begin
              tx_reg    <= {tx_reg[6:0], 1'b0};
              mosi_reg  <= tx_reg[6];
              state_reg <= H_LOW;
            end
          end
        H_FETCH:
        begin
          half_reg <= 4'h0;
          // pads with zero bytes when the user ends on a short count
          if (last_reg || f_valid)
          begin
            tx_reg    <= (last_reg || read_reg) ? 8'h00 : f_data[7:0];
            mosi_reg  <= !last_reg && !read_reg && f_data[7];
            last_reg  <= last_reg || f_data[8];
            state_reg <= H_LOW;
          end
        end
        H_END:
          if (half_done)
          begin
            cs_n_reg  <= 1'b1;
            state_reg <= H_GAP;
          end
        H_GAP:
          if (half_done)
            state_reg <= H_IDLE;
        default:
          state_reg <= H_IDLE;
      endcase
    end
endmodule : radio_spi_host
`default_nettype wire

// ### rtl/radio_mode_ctrl.sv
// device end: serial slave, register store and power-mode sequencer
`timescale 1ns/100ps
`default_nettype none
// Function
// - reset release goes Off to Idle
// - Off tristates outputs; power-up delay to Idle
// - Idle serves port; sleep only by command
// - Hibernate: clock stopped, port dead, attention wakes
// - Doze: port dead, clock out gated
// - Doze wakes on attention or timer match
// - radio warm-up from Idle takes 144 us
// - slave only, never drives serial clock
// - host holds select low, three bursts minimum
// - clock idles low, sample rise, shift fall
// - eight-bit bursts, msb first
// - first burst is header: address and direction
// - payload moves one direction only
// - payload even, at least two bytes
// - host raises select after last burst
// - serial pins sampled, transfers on core clock
// - sequence enable starts radio, low forces Idle
module radio_mode_ctrl #(
  parameter int unsigned POWER_UP_CYCLES = radio_spi_pkg::OFF_TO_IDLE_CYCLES,
  parameter int unsigned HIB_WAKE_CYCLES = radio_spi_pkg::HIB_TO_IDLE_CYCLES
) (
  input  wire logic         core_clk_in,
  input  wire logic         resetn_in,
  input  wire logic         clk_en_in,
  spi_link_if.device        link,
  output logic [3:0]        mode_out,
  output logic              osc_on_out,
  output logic              rx_on_out,
  output logic              tx_on_out
);
  import radio_spi_pkg::*;

  // ==========================================================================
  // pin synchronisers
  localparam int unsigned SYN_W = 5;
  // pins reset to their idle levels so no false edge follows reset
  localparam logic [SYN_W-1:0] SYN_IDLE = 5'h0A;

  logic [SYN_W-1:0] sync1_reg;
  logic [SYN_W-1:0] sync2_reg;
  logic             sclk_prev_reg;
  logic             seq_prev_reg;

  wire sclk_s   = sync2_reg[4];
  wire cs_n_s   = sync2_reg[3];
  wire mosi_s   = sync2_reg[2];
  wire wake_attention_n_n_s = sync2_reg[1];
  wire seq_s    = sync2_reg[0];

  // ==========================================================================
  // state
  mode_t             state_reg;
  mode_t             state_next;
  logic [WAIT_W-1:0] wait_reg;
  logic [WAIT_W-1:0] wait_next;
  logic              wait_load;
  logic [15:0]       regs_reg [REG_COUNT];
  logic [15:0]       doze_cnt_reg;
  logic [2:0]        bit_reg;
  logic [7:0]        shift_reg;
  logic [7:0]        tx_reg;
  logic [7:0]        hi_reg;
  logic [5:0]        addr_reg;
  logic [5:0]        word_reg;
  logic              payload_reg;
  logic              read_reg;
  logic              hi_phase_reg;
  logic [3:0]        clock_output_cnt_reg;
  logic              miso_reg;
  logic              miso_oe_n_reg;
  logic              clock_output_reg;
  logic              clock_output_oe_n_reg;
  logic              irq_oe_n_reg;

  // ==========================================================================
  // decoding
  // the port listens in Idle and while the radio runs; sleep modes ignore it
  wire spi_active = state_reg == M_IDLE || state_reg == M_RX_WARM ||
                    state_reg == M_RX || state_reg == M_TX_WARM ||
                    state_reg == M_TX;
  // only edges of the host clock advance the shifter
  wire rise = spi_active && !cs_n_s && sclk_s && !sclk_prev_reg;
  wire fall = spi_active && !cs_n_s && !sclk_s && sclk_prev_reg;
  wire [7:0] rx_byte   = {shift_reg[6:0], mosi_s};
  wire       byte_done = rise && bit_reg == 3'h7;
  wire [2:0] idx       = reg_index(addr_reg, word_reg);
  wire [2:0] idx_nxt   = reg_index(addr_reg, word_reg + 6'h01);
  wire [2:0] idx_hdr   = reg_index(rx_byte[HDR_ADDR_W-1:0], 6'h00);
  wire       wr_word   = byte_done && payload_reg && !read_reg &&
                         hi_phase_reg;
  wire [15:0] wr_data  = {hi_reg, rx_byte};
  wire       cmd_write = wr_word && idx == MODE_REG_IDX;
  wire [1:0] cmd       = wr_data[1:0];
  wire       seq_rise  = seq_s && !seq_prev_reg;
  wire       seq_tx    = regs_reg[MODE_REG_IDX][MODE_TX_BIT];
  wire [15:0] doze_cmp = regs_reg[DOZE_TIMER_IDX];
  wire       timer_hit = doze_cmp != 16'h0000 && doze_cnt_reg == doze_cmp;
  wire [CLOCK_OUTPUT_DIV_W-1:0] clock_output_div = regs_reg[CLOCK_OUTPUT_CTRL_IDX][CLOCK_OUTPUT_DIV_W-1:0];
  wire       doze_clock_output = regs_reg[CLOCK_OUTPUT_CTRL_IDX][CLOCK_OUTPUT_EN_BIT] &&
                         clock_output_div >= CLOCK_OUTPUT_MIN_DIV;
  wire       clock_output_run  = spi_active || (state_reg == M_DOZE && doze_clock_output);
  // one period of the clock output is two half periods of div+1 cycles
  wire [WAIT_W-1:0] clock_output_period = WAIT_W'({clock_output_div, 1'b0}) + WAIT_W'(2);
  wire       wait_zero = wait_reg == '0;

  // ==========================================================================
  // mode sequencer
  always_comb
  begin
    state_next = state_reg;
    wait_next  = wait_zero ? wait_reg : wait_reg - WAIT_W'(1);
    wait_load  = 1'b0;
    unique case (state_reg)
      M_OFF:
      begin
        state_next = M_POWER_UP;
        wait_next  = WAIT_W'(POWER_UP_CYCLES - 1);
      end
      M_POWER_UP:
        if (wait_zero)
          state_next = M_IDLE;
      M_IDLE:
        if (cmd_write && cmd == CMD_HIBERNATE)
          state_next = M_HIBERNATE;
        else if (cmd_write && cmd == CMD_DOZE)
          state_next = M_DOZE;
        else if (seq_rise)
        begin
          state_next = seq_tx ? M_TX_WARM : M_RX_WARM;
          wait_next  = WAIT_W'(RADIO_WARM_CYCLES - 1);
        end
      M_HIBERNATE:
        if (!wake_attention_n_n_s)
        begin
          state_next = M_HIB_WAKE;
          wait_next  = WAIT_W'(HIB_WAKE_CYCLES - 1);
        end
      M_HIB_WAKE:
        if (wait_zero)
          state_next = M_IDLE;
      M_DOZE:
        if (!wake_attention_n_n_s || timer_hit)
        begin
          state_next = M_DOZE_WAKE;
          wait_load  = 1'b1;
        end
      M_DOZE_WAKE:
        if (wait_zero)
          state_next = M_IDLE;
      M_RX_WARM,
      M_TX_WARM:
        if (!seq_s)
          state_next = M_IDLE;
        else if (wait_zero)
          state_next = (state_reg == M_TX_WARM) ? M_TX : M_RX;
      M_RX,
      M_TX:
        if (!seq_s)
          state_next = M_IDLE;
      default:
        state_next = M_OFF;
    endcase
    if (wait_load)
      wait_next = WAIT_W'(DOZE_WAKE_CYCLES - 1) + clock_output_period;
  end

  assign mode_out           = state_reg;
  assign link.miso          = miso_reg;
  assign link.miso_oe_n     = miso_oe_n_reg;
  assign link.clock_output  = clock_output_reg;
  assign link.clock_output_oe_n = clock_output_oe_n_reg;
  assign link.irq_n         = 1'b1;
  assign link.irq_oe_n      = irq_oe_n_reg;

  // ==========================================================================
  // sequential logic
  always_ff @(posedge core_clk_in)
    if (!resetn_in)
    begin
      sync1_reg     <= SYN_IDLE;
      sync2_reg     <= SYN_IDLE;
      sclk_prev_reg <= 1'b0;
      seq_prev_reg  <= 1'b0;
      state_reg     <= M_OFF;
      wait_reg      <= '0;
      doze_cnt_reg  <= 16'h0000;
      for (int i = 0; i < REG_COUNT; i++)
        regs_reg[i] <= (i == int'(CLOCK_OUTPUT_CTRL_IDX)) ? CLOCK_OUTPUT_CTRL_RESET
                                                  : REG_RESET;
      bit_reg       <= 3'h0;
      shift_reg     <= 8'h00;
      tx_reg        <= 8'h00;
      hi_reg        <= 8'h00;
      addr_reg      <= 6'h00;
      word_reg      <= 6'h00;
      payload_reg   <= 1'b0;
      read_reg      <= 1'b0;
      hi_phase_reg  <= 1'b0;
      clock_output_cnt_reg  <= 4'h0;
      miso_reg      <= 1'b0;
      miso_oe_n_reg <= 1'b1;
      clock_output_reg      <= 1'b0;
      clock_output_oe_n_reg <= 1'b1;
      irq_oe_n_reg  <= 1'b1;
      osc_on_out    <= 1'b0;
      rx_on_out     <= 1'b0;
      tx_on_out     <= 1'b0;
    end
    else if (clk_en_in)
    begin
      sync1_reg     <= {link.sclk, link.cs_n, link.mosi,
                        link.attention_n, link.seq_enable};
      sync2_reg     <= sync1_reg;
      sclk_prev_reg <= sclk_s;
      seq_prev_reg  <= seq_s;
      state_reg     <= state_next;
      wait_reg      <= wait_next;
      doze_cnt_reg  <= (state_reg == M_DOZE) ? doze_cnt_reg + 16'h0001
                                             : 16'h0000;
      irq_oe_n_reg  <= state_next == M_OFF;
      osc_on_out    <= state_next != M_HIBERNATE;
      rx_on_out     <= state_next == M_RX_WARM || state_next == M_RX;
      tx_on_out     <= state_next == M_TX_WARM || state_next == M_TX;
      // clock output: stopped with the oscillator, gated in doze
      clock_output_oe_n_reg <= !clock_output_run;
      if (clock_output_run)
      begin
        clock_output_cnt_reg <= (clock_output_cnt_reg == clock_output_div) ? 4'h0
                                                   : clock_output_cnt_reg + 4'h1;
        if (clock_output_cnt_reg == clock_output_div)
          clock_output_reg <= !clock_output_reg;
      end
      else
      begin
        clock_output_cnt_reg <= 4'h0;
        clock_output_reg     <= 1'b0;
      end
      // serial slave; register store keeps its contents in sleep modes
      miso_oe_n_reg <= cs_n_s || !spi_active;
      if (cs_n_s || !spi_active)
      begin
        bit_reg      <= 3'h0;
        payload_reg  <= 1'b0;
        hi_phase_reg <= 1'b0;
        word_reg     <= 6'h00;
        tx_reg       <= 8'h00;
        miso_reg     <= 1'b0;
      end
      else
      begin
        if (fall)
          miso_reg <= tx_reg[~bit_reg];
        if (rise)
        begin
          shift_reg <= rx_byte;
          bit_reg   <= bit_reg + 3'h1;
        end
        if (byte_done && !payload_reg)
        begin
          payload_reg <= 1'b1;
          read_reg    <= rx_byte[HDR_RW_BIT];
          addr_reg    <= rx_byte[HDR_ADDR_W-1:0];
          tx_reg      <= rx_byte[HDR_RW_BIT] ? regs_reg[idx_hdr][15:8]
                                             : 8'h00;
        end
        else if (byte_done)
        begin
          hi_phase_reg <= !hi_phase_reg;
          hi_reg       <= rx_byte;
          if (hi_phase_reg)
            word_reg <= word_reg + 6'h01;
          if (wr_word)
            regs_reg[idx] <= wr_data;
          if (read_reg)
            tx_reg <= hi_phase_reg ? regs_reg[idx_nxt][15:8]
                                   : regs_reg[idx][7:0];
        end
      end
    end
endmodule : radio_mode_ctrl
`default_nettype wire

// ### testbench/radio_link_asserts.sv
// wire-level checker for the host-device link
`timescale 1ns/100ps
`default_nettype none
module radio_link_asserts (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe_n,
  input wire logic clock_output_oe_n,
  input wire logic irq_oe_n
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);
  // ======
  // rising edges seen in the current frame
  logic       sclk_q;
  logic [7:0] rises;
  always_ff @(posedge core_clk_in)
  begin
    sclk_q <= sclk;
    rises <= (cs_n || !resetn_in) ? 8'h00 : rises + {7'h00, sclk & ~sclk_q};
  end
  a_sclk_idle: assert property (cs_n |-> !sclk)
    else $error("clock active while deselected");
  a_off_hiz: assert property ($rose(resetn_in) |-> miso_oe_n
    && clock_output_oe_n && irq_oe_n) else $error("output driven in reset");
  a_miso_free: assert property ($rose(cs_n) |-> ##[2:4] miso_oe_n)
    else $error("data out not released");
  a_miso_off: assert property (cs_n[*4] |-> miso_oe_n)
    else $error("data out driven while deselected");
  a_miso_hold: assert property (sclk && !miso_oe_n |-> $stable(miso))
    else $error("data out moved while clock high");
  a_mosi_hold: assert property (sclk |-> $stable(mosi))
    else $error("data in moved while clock high");
  a_half_per: assert property ($rose(sclk) |-> sclk[*8] ##1 !sclk)
    else $error("clock half period wrong");
  a_frame_len: assert property ($rose(cs_n) |-> rises >= 8'd24
    && rises[3:0] == 4'h8) else $error("frame bit count wrong");
  a_hdr_quiet: assert property (!cs_n && rises < 8'd8 && !miso_oe_n
    |-> !miso) else $error("data out during header");
endmodule : radio_link_asserts
`default_nettype wire

// ### testbench/radio_spi_slave_mode_ctrl_tb_top.sv
// bench joining host and device ends over the link
`timescale 1ns/100ps
`default_nettype none
module radio_spi_slave_mode_ctrl_tb_top;
  import radio_spi_pkg::*;
  logic core_clk_in, resetn_in, seq_enable_in, wake_req_in;
  logic clk_en_in, clock_output_seen;
  logic [7:0] cmd_data_in, rsp_data_out;
  logic cmd_last_in, cmd_valid_in, cmd_ready_out, rsp_valid_out, busy_out;
  logic [3:0] mode_out;
  logic osc_on_out, rx_on_out, tx_on_out;
  int n_fail = 0;
  int cmp_count = 0;
  logic [7:0] rq[$];
  spi_link_if link ();
  radio_spi_host u_radio_spi_host (.core_clk_in, .resetn_in,
    .clk_en_in, .link(link), .cmd_data_in, .cmd_last_in,
    .cmd_valid_in, .cmd_ready_out, .rsp_data_out, .rsp_valid_out,
    .busy_out, .wake_req_in, .seq_enable_in);
  radio_mode_ctrl #(.POWER_UP_CYCLES(20), .HIB_WAKE_CYCLES(10))
    u_radio_mode_ctrl (.core_clk_in, .resetn_in, .clk_en_in,
    .link(link), .mode_out, .osc_on_out, .rx_on_out, .tx_on_out);
  radio_link_asserts u_radio_link_asserts (.core_clk_in, .resetn_in,
    .sclk(link.sclk), .cs_n(link.cs_n), .mosi(link.mosi),
    .miso(link.miso), .miso_oe_n(link.miso_oe_n),
    .clock_output_oe_n(link.clock_output_oe_n), .irq_oe_n(link.irq_oe_n));
  // ======
  // access tasks
  task automatic step();
    @(posedge core_clk_in);
    #10;
  endtask : step
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("wrong value t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // valid stays up between bytes so it is never set twice in one step
  task automatic put(input logic [7:0] d, input logic l);
    cmd_data_in = d;
    cmd_last_in = l;
    cmd_valid_in = 1'b1;
    while (!cmd_ready_out) step();
    step();
  endtask : put
  task automatic txn(input logic [7:0] h, input logic [15:0] a, b,
                     input int n);
    put(h, 1'b0);
    put(a[15:8], 1'b0);
    put(a[7:0], n == 1);
    if (n == 2)
    begin
      put(b[15:8], 1'b0);
      put(b[7:0], 1'b1);
    end
    cmd_valid_in = 1'b0;
    step();
    while (busy_out) step();
  endtask : txn
  task automatic rd(input logic [7:0] h, input logic [15:0] e);
    rq.delete();
    txn(h, 16'h0000, 16'h0000, 1);
    chk({rq[0], rq[1]}, e);
  endtask : rd
  task automatic await(input mode_t m, input int lim);
    for (int i = 0; i < lim && mode_out !== m; i++) step();
    chk(16'(mode_out), 16'(m));
  endtask : await
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  always @(negedge core_clk_in)
    if (rsp_valid_out === 1'b1) rq.push_back(rsp_data_out);
  initial
  begin
    core_clk_in = 1'b0;
    forever #50 core_clk_in = ~core_clk_in;
  end
  initial
  begin
    repeat (40000) @(posedge core_clk_in);
    n_fail++;
    tally_and_finish();
  end
  initial
  begin
    {resetn_in, seq_enable_in, wake_req_in, cmd_valid_in} = 4'h0;
    clk_en_in = 1'b1;
    {cmd_data_in, cmd_last_in} = 9'h000;
    repeat (20) step();
    resetn_in = 1'b1;
    await(M_POWER_UP, 2);
    await(M_IDLE, 40);
    step();
    chk({15'h0, link.clock_output_oe_n}, 16'h0000);
    clock_output_seen = link.clock_output;
    repeat (CLOCK_OUTPUT_CTRL_RESET[3:0] + 1) step();
    chk({15'h0, link.clock_output}, {15'h0, ~clock_output_seen});
    rd(8'h87, CLOCK_OUTPUT_CTRL_RESET);
    txn(8'h03, 16'h1234, 16'hA5C3, 2);
    rd(8'h84, 16'hA5C3);
    rd(8'hC3, 16'h1234);
    for (int k = 0; k < 2; k++)
    begin
      txn(8'h01, 16'(k << 2), 16'h0000, 1);
      seq_enable_in = 1'b1;
      await(k ? M_TX_WARM : M_RX_WARM, 8);
      // a frozen clock enable stretches the warm-up by the frozen cycles
      clk_en_in = 1'b0;
      repeat (40) step();
      clk_en_in = 1'b1;
      repeat (1400) step();
      await(k ? M_TX_WARM : M_RX_WARM, 0);
      await(k ? M_TX : M_RX, 60);
      chk({14'h0, tx_on_out, rx_on_out}, k ? 16'h2 : 16'h1);
      seq_enable_in = 1'b0;
      await(M_IDLE, 8);
    end
    txn(8'h01, 16'h0001, 16'h0000, 1);
    await(M_HIBERNATE, 10);
    chk({15'h0, osc_on_out}, 16'h0000);
    rd(8'h83, 16'h0000);
    wake_req_in = 1'b1;
    await(M_HIB_WAKE, 8);
    wake_req_in = 1'b0;
    await(M_IDLE, 30);
    rd(8'h83, 16'h1234);
    txn(8'h02, 16'd200, 16'h0000, 1);
    txn(8'h01, 16'h0002, 16'h0000, 1);
    await(M_DOZE, 10);
    repeat (150) step();
    chk({15'h0, link.clock_output_oe_n}, 16'h0001);
    await(M_DOZE, 0);
    await(M_DOZE_WAKE, 80);
    repeat (3000) step();
    await(M_DOZE_WAKE, 0);
    await(M_IDLE, 60);
    resetn_in = 1'b0;
    repeat (4) step();
    chk(16'(mode_out), 16'(M_OFF));
    chk({13'h0, osc_on_out, link.miso_oe_n, link.irq_oe_n}, 16'h0003);
    resetn_in = 1'b1;
    await(M_POWER_UP, 2);
    await(M_IDLE, 40);
    rd(8'h83, REG_RESET);
    tally_and_finish();
  end
endmodule : radio_spi_slave_mode_ctrl_tb_top
`default_nettype wire
